// ===== tx_app_pkg.sv
// Shared constants of the two-channel transmit application interface
package tx_app_pkg;

	// ----------------------------------------------------------------
	// Channel and data geometry
	// ----------------------------------------------------------------
	localparam int NUM_CH        = 2;   // Channels 0 and 1
	localparam int BYTE_W        = 8;   // Bits per byte lane
	localparam int DATA_W_DEF    = 128; // Channel data width: 128, 256 or 512
	localparam int CAL_PAGES_DEF = 1;   // Calendar pages: 1, 8 or 16

	// ----------------------------------------------------------------
	// Outgoing control word layout
	// ----------------------------------------------------------------
	localparam int CAL_PAGE_W = 16;  // Bits per calendar page
	localparam int CW_W       = 64;  // Link control word width
	localparam int CW_CAL_LSB = 40;  // Page field low bit
	localparam int CW_CAL_MSB = 55;  // Page field high bit

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [NUM_CH-1:0] CH_EN_RST = 2'h0; // Channels start disabled
	localparam logic              LAST_RST  = 1'h1; // Channel 0 wins first

endpackage

// ===== tx_app_if.sv
// Interface joining the application end and the arbiter end
`timescale 1ns/10ps
interface tx_app_if #(
	parameter int DATA_W    = 128,
	parameter int EMPTY_W   = $clog2(DATA_W / 8),
	parameter int CAL_PAGES = 1
) ();

	// Per-channel streams, index 0 is channel 0
	logic [1:0][DATA_W-1:0]  data;
	logic [1:0]              valid;
	logic [1:0]              ready;
	logic [1:0]              sop;
	logic [1:0]              eop;
	logic [1:0]              err;
	logic [1:0][EMPTY_W-1:0] empty;

	// Control inputs of the arbiter
	logic                    force_transmit;
	logic [1:0]              chan_en;
	logic [16*CAL_PAGES-1:0] tx_calendar;

	// Arbiter end
	modport dev (
		input  data, valid, sop, eop, err, empty,
		input  force_transmit, chan_en, tx_calendar,
		output ready
	);

	// Application end
	modport app (
		output data, valid, sop, eop, err, empty,
		output force_transmit, chan_en, tx_calendar,
		input  ready
	);

endinterface

// ===== tx_app_src.sv
// Application end: registers user packet streams onto the two channels
`timescale 1ns/10ps
module tx_app_src
	import tx_app_pkg::*;
#(
	parameter int DATA_W    = DATA_W_DEF,
	parameter int EMPTY_W   = $clog2(DATA_W / BYTE_W),
	parameter int CAL_PAGES = CAL_PAGES_DEF
) (
	// Clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        rst_n,
	// Link-facing channel pair
	tx_app_if.app                            bus,
	// User words, one slot per channel
	input  wire logic [1:0]                  usr_valid,
	input  wire logic [1:0]                  usr_eop,
	input  wire logic [1:0]                  usr_err,
	input  wire logic [1:0][EMPTY_W-1:0]     usr_empty,
	input  wire logic [1:0][DATA_W-1:0]      usr_data,
	output logic      [1:0]                  usr_ready,
	// Control settings
	input  wire logic                        cfg_force,
	input  wire logic [1:0]                  cfg_chan_en,
	input  wire logic [CAL_PAGE_W*CAL_PAGES-1:0] cfg_calendar
);

	// ----------------------------------------------------------------
	// Per-channel stream stage
	// ----------------------------------------------------------------
	logic [1:0] valid_r;
	logic [1:0] in_pkt_r;
	logic [1:0] pop;
	logic [1:0] load;
	logic [1:0] valid_nxt;

	// Word leaves when arbiter ready meets our valid
	assign pop       = valid_r & bus.ready;
	assign valid_nxt = (valid_r & ~pop) | load;
	assign load      = usr_valid & usr_ready;

	// Valid only while a word is held; one process keeps each bus field single-driven
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			valid_r   <= 2'h0;
			in_pkt_r  <= 2'h0;
			usr_ready <= 2'h0;
			bus.sop   <= 2'h0;
			bus.eop   <= 2'h0;
			bus.err   <= 2'h0;
			bus.empty <= '0;
			bus.data  <= '0;
		end else begin
			valid_r   <= valid_nxt;
			usr_ready <= ~valid_nxt;
			for (int c = 0; c < NUM_CH; c++) begin
				if (load[c]) begin
					bus.data[c]  <= usr_data[c];
					bus.sop[c]   <= ~in_pkt_r[c];
					bus.eop[c]   <= usr_eop[c];
					bus.err[c]   <= usr_err[c] & usr_eop[c];
					bus.empty[c] <= usr_eop[c] ? usr_empty[c] : '0;
					in_pkt_r[c]  <= ~usr_eop[c];
				end
			end
		end
	end

	assign bus.valid = valid_r;

	// ----------------------------------------------------------------
	// Control settings, registered toward the arbiter
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus.force_transmit <= 1'b0;
			bus.chan_en        <= CH_EN_RST;
			bus.tx_calendar    <= '0;
		end else begin
			bus.force_transmit <= cfg_force;
			bus.chan_en        <= cfg_chan_en;
			bus.tx_calendar    <= cfg_calendar;
		end
	end

endmodule // tx_app_src

// ===== tx_app_arb.sv
// Arbiter end: grants the two channels and builds calendar control words
//
// Notes on behaviour
// - Two independent channels, 0 and 1.
// - Everything but the asynchronous rst_n reset on rising sys_clk edges.
// - Application picks suitably fast MAC clock.
// - Channel data 128, 256 or 512 bits.
// - Capture only when valid and ready.
// - Valid marks exactly the meaningful words.
// - Ready low holds the channel stream back.
// - Start flag on packet's first word.
// - End flag on packet's last word.
// - Error honoured only on end words.
// - Empty counts void bytes from LSB.
// - Empty width is 4, 5 or 6.
// - Force ignores received calendar on enabled channels.
// - Disabled channel gets no ready from one cycle after chan_en drops.
// - One calendar page per control word, 55:40.
// - Calendar input is 16 per page.
`timescale 1ns/10ps
module tx_app_arb
	import tx_app_pkg::*;
#(
	parameter int DATA_W    = DATA_W_DEF,
	parameter int EMPTY_W   = $clog2(DATA_W / BYTE_W),
	parameter int CAL_PAGES = CAL_PAGES_DEF,
	parameter int PAGE_IW   = (CAL_PAGES > 1) ? $clog2(CAL_PAGES) : 1
) (
	// Clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     rst_n,
	// Application channel pair
	tx_app_if.dev                         bus,
	// In-band calendar received from the partner, one bit per channel
	input  wire logic [1:0]               link_xon,
	// Merged word stream toward the framer
	input  wire logic                     link_ready,
	output logic                          link_valid,
	output logic                          link_ch,
	output logic                          link_sop,
	output logic                          link_eop,
	output logic                          link_err,
	output logic      [EMPTY_W-1:0]       link_empty,
	output logic      [DATA_W/BYTE_W-1:0] link_keep,
	output logic      [DATA_W-1:0]        link_data,
	// Control word request and answer
	input  wire logic                     ctl_req,
	output logic                          ctl_valid,
	output logic      [PAGE_IW-1:0]       ctl_page,
	output logic      [CW_W-1:0]          ctl_word
);

	localparam int NBYTES = DATA_W / BYTE_W;

	// ----------------------------------------------------------------
	// Eligibility and capture
	// ----------------------------------------------------------------
	logic [1:0] ready_r;
	logic [1:0] elig;
	logic [1:0] cap;
	logic       cap_any;
	logic       cap_ch;

	// Enabled channels pass; partner's calendar gates them unless forced
	assign elig    = bus.chan_en & ({2{bus.force_transmit}} | link_xon);
	assign cap     = ready_r & bus.valid;
	assign cap_any = |cap;
	assign cap_ch  = cap[1];

	// Fields of the captured word
	logic                    sel_sop;
	logic                    sel_eop;
	logic                    sel_err;
	logic [EMPTY_W-1:0]      sel_empty;
	logic [DATA_W-1:0]       sel_data;
	logic [NBYTES-1:0]       void_mask;
	logic [NBYTES-1:0]       sel_keep;

	assign sel_sop   = bus.sop[cap_ch];
	assign sel_eop   = bus.eop[cap_ch];
	assign sel_err   = bus.err[cap_ch] & sel_eop;
	assign sel_empty = sel_eop ? bus.empty[cap_ch] : '0;
	assign sel_data  = bus.data[cap_ch];

	// Byte lanes below the empty count are void, counted from the LSB
	generate
		for (genvar i = 0; i < NBYTES; i++) begin : g_keep
			assign void_mask[i] = (EMPTY_W'(i) < sel_empty);
		end
	endgenerate
	assign sel_keep = ~void_mask;

	// ----------------------------------------------------------------
	// Output slot and packet lock
	// ----------------------------------------------------------------
	logic out_valid_nxt;
	logic lock_r;
	logic lock_ch_r;
	logic last_r;
	logic lock_nxt;
	logic lock_ch_nxt;
	logic last_nxt;
	logic rr_pick;
	logic gsel;
	logic [1:0] ready_nxt;

	// Slot fills on capture and drains when the framer takes it
	assign out_valid_nxt = cap_any | (link_valid & ~link_ready);

	// A channel keeps the grant from its start word to its end word
	assign lock_nxt    = cap_any ? ~sel_eop : lock_r;
	assign lock_ch_nxt = cap_any ? cap_ch : lock_ch_r;
	assign last_nxt    = cap_any ? cap_ch : last_r;

	// Round robin at packet boundaries: the other channel first
	assign rr_pick = (elig[~last_nxt] & bus.valid[~last_nxt]) ? ~last_nxt : last_nxt;
	assign gsel    = lock_nxt ? lock_ch_nxt : rr_pick;

	// Ready only when the slot is free next cycle and the channel may send
	assign ready_nxt[0] = elig[0] & ~out_valid_nxt & ~gsel;
	assign ready_nxt[1] = elig[1] & ~out_valid_nxt & gsel;

	// Grant state
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_r   <= 2'h0;
			lock_r    <= 1'b0;
			lock_ch_r <= 1'b0;
			last_r    <= LAST_RST;
		end else begin
			ready_r   <= ready_nxt;
			lock_r    <= lock_nxt;
			lock_ch_r <= lock_ch_nxt;
			last_r    <= last_nxt;
		end
	end

	assign bus.ready = ready_r;

	// Merged stream slot
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			link_valid <= 1'b0;
			link_ch    <= 1'b0;
			link_sop   <= 1'b0;
			link_eop   <= 1'b0;
			link_err   <= 1'b0;
			link_empty <= '0;
			link_keep  <= '0;
			link_data  <= '0;
		end else begin
			link_valid <= out_valid_nxt;
			if (cap_any) begin
				link_ch    <= cap_ch;
				link_sop   <= sel_sop;
				link_eop   <= sel_eop;
				link_err   <= sel_err;
				link_empty <= sel_empty;
				link_keep  <= sel_keep;
				link_data  <= sel_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// Calendar control words
	// ----------------------------------------------------------------
	logic [PAGE_IW-1:0]    page_r;
	logic [PAGE_IW-1:0]    page_nxt;
	logic [CAL_PAGE_W-1:0] page_bits;
	logic [CW_W-1:0]       word_nxt;

	// Pages go out in order, wrapping after the last
	assign page_nxt = (32'(page_r) == CAL_PAGES - 1) ? '0 : page_r + PAGE_IW'(1);
	assign page_bits = bus.tx_calendar[32'(page_r)*CAL_PAGE_W +: CAL_PAGE_W];

	// One page sits in the page field, all other bits clear
	always_comb begin
		word_nxt = '0;
		word_nxt[CW_CAL_MSB:CW_CAL_LSB] = page_bits;
	end

	// Answer each request with the current page, then advance
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			page_r    <= '0;
			ctl_valid <= 1'b0;
			ctl_page  <= '0;
			ctl_word  <= '0;
		end else begin
			ctl_valid <= ctl_req;
			if (ctl_req) begin
				ctl_word <= word_nxt;
				ctl_page <= page_r;
				page_r   <= page_nxt;
			end
		end
	end

endmodule // tx_app_arb

// ===== tx_app_props.sv
// Concurrent checks on the channel pair between the application and arbiter ends
`timescale 1ns/10ps
module tx_app_props #(
	parameter int DATA_W  = 128,
	parameter int EMPTY_W = 4
) (
	// Clock and reset
	input wire logic                     sys_clk,
	input wire logic                     rst_n,
	// Channel pair
	input wire logic [1:0][DATA_W-1:0]  data,
	input wire logic [1:0]              valid,
	input wire logic [1:0]              ready,
	input wire logic [1:0]              eop,
	input wire logic [1:0]              err,
	input wire logic [1:0][EMPTY_W-1:0] empty,
	input wire logic [1:0]              chan_en
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// Grants and handshake
	// ------------------------------------------------------------
	ch0_off_a: assert property (!chan_en[0] && !$past(chan_en[0]) |-> !ready[0])
		else $error("ready on disabled channel 0");
	ch1_off_a: assert property (!chan_en[1] && !$past(chan_en[1]) |-> !ready[1])
		else $error("ready on disabled channel 1");
	ch0_hold_a: assert property (valid[0] && !ready[0] |=> valid[0] && $stable(data[0]))
		else $error("channel 0 word left before taken");
	ch1_hold_a: assert property (valid[1] && !ready[1] |=> valid[1] && $stable(data[1]))
		else $error("channel 1 word left before taken");
	ch0_take_a: assert property (valid[0] && ready[0] |=> !ready[0])
		else $error("channel 0 ready stayed after take");
	ch1_take_a: assert property (valid[1] && ready[1] |=> !ready[1])
		else $error("channel 1 ready stayed after take");

	// ------------------------------------------------------------
	// Qualifiers
	// ------------------------------------------------------------
	err_on_eop_a: assert property ((err & ~eop) == 2'h0)
		else $error("error flag off an end word");
	empty_on_eop_a: assert property (!((|empty[0] && !eop[0]) || (|empty[1] && !eop[1])))
		else $error("empty count off an end word");

	// Main scenarios
	cover property (valid[0] && ready[0]);
	cover property (valid[1] && ready[1]);
	cover property (valid[0] && ready[0] && eop[0] && err[0]);
endmodule // tx_app_props

// ===== testbench.sv
// Self-checking bench joining both ends through the channel interface
`timescale 1ns/10ps
module testbench;
	import tx_app_pkg::*;
	typedef struct packed {logic c; logic e; logic r; logic [3:0] m; logic [31:0] d;} row_t;
	logic              sys_clk, rst_n, cfg_force, link_ready, ctl_req;
	logic              link_valid, link_ch, link_sop, link_eop, link_err, ctl_valid;
	logic [1:0]        usr_valid, usr_eop, usr_err, usr_ready, cfg_chan_en, link_xon, open_pkt;
	logic [1:0][3:0]   usr_empty;
	logic [1:0][127:0] usr_data;
	logic [31:0]       cfg_calendar;
	logic [3:0]        link_empty;
	logic [15:0]       link_keep;
	logic [127:0]      link_data;
	logic [0:0]        ctl_page;
	logic [63:0]       ctl_word;
	int                n_fail, checked;
	row_t rows [6] = '{'{1'h0, 1'h0, 1'h1, 4'h5, 32'ha0a0_0001}, '{1'h0, 1'h1, 1'h1, 4'h3, 32'ha0a0_0002},
		'{1'h1, 1'h1, 1'h0, 4'h0, 32'hb1b1_0003}, '{1'h1, 1'h0, 1'h0, 4'h0, 32'hb1b1_0004},
		'{1'h1, 1'h1, 1'h1, 4'hf, 32'hb1b1_0005}, '{1'h0, 1'h1, 1'h0, 4'h1, 32'ha0a0_0006}};

	tx_app_if #(.DATA_W(128), .EMPTY_W(4), .CAL_PAGES(2)) bus ();
	tx_app_src #(.CAL_PAGES(2)) tx_app_src_inst (.sys_clk, .rst_n, .bus, .usr_valid, .usr_eop,
		.usr_err, .usr_empty, .usr_data, .usr_ready, .cfg_force, .cfg_chan_en, .cfg_calendar);
	tx_app_arb #(.CAL_PAGES(2)) tx_app_arb_inst (.sys_clk, .rst_n, .bus, .link_xon, .link_ready,
		.link_valid, .link_ch, .link_sop, .link_eop, .link_err, .link_empty, .link_keep,
		.link_data, .ctl_req, .ctl_valid, .ctl_page, .ctl_word);
	tx_app_props #(.DATA_W(128), .EMPTY_W(4)) tx_app_props_inst (.sys_clk, .rst_n,
		.data(bus.data), .valid(bus.valid), .ready(bus.ready), .eop(bus.eop), .err(bus.err),
		.empty(bus.empty), .chan_en(bus.chan_en));

	// Clock
	initial begin
		sys_clk = 1'h0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic hang;
		n_fail++;
		report_and_stop();
	endtask

	// Offer one user word and release it after it is taken
	task automatic offer(input row_t w);
		int i;
		usr_valid[w.c] = 1'h1;
		usr_eop[w.c] = w.e;
		usr_err[w.c] = w.r;
		usr_empty[w.c] = w.m;
		usr_data[w.c] = {4{w.d}};
		for (i = 0; i < 60 && usr_ready[w.c] !== 1'h1; i++) @(negedge sys_clk);
		if (i == 60) hang();
		@(negedge sys_clk);
		usr_valid[w.c] = 1'h0;
	endtask

	// Wait for the merged word and compare every field
	task automatic take(input row_t w);
		int i;
		for (i = 0; i < 60 && link_valid !== 1'h1; i++) @(negedge sys_clk);
		if (i == 60) hang();
		chk({link_ch, link_sop, link_eop, link_err}, {w.c, !open_pkt[w.c], w.e, w.e & w.r});
		chk(link_empty, w.e ? w.m : 4'h0);
		chk(link_keep, w.e ? 16'(16'hffff << w.m) : 16'hffff);
		chk(link_data, {4{w.d}});
		open_pkt[w.c] = !w.e;
		@(negedge sys_clk);
	endtask

	task automatic quiet;
		repeat (20) begin
			@(negedge sys_clk);
			chk(link_valid, 1'h0);
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{rst_n, cfg_force, ctl_req, usr_valid, usr_eop, usr_err, open_pkt} = 11'h0;
		usr_empty = 8'h00;
		usr_data = 256'h0;
		{cfg_chan_en, link_xon, link_ready} = 5'h1f;
		cfg_calendar = 32'h5a5a_c3c3;
		n_fail = 0;
		checked = 0;
		repeat (16) @(negedge sys_clk);
		chk({link_valid, ctl_valid}, 2'h0);
		rst_n = 1'h1;
		repeat (4) @(negedge sys_clk);
		foreach (rows[k]) begin
			offer(rows[k]);
			take(rows[k]);
		end
		// Enable reaches ready two edges late, so let it settle before offering
		cfg_chan_en = 2'h2;
		repeat (3) @(negedge sys_clk);
		offer(rows[5]);
		quiet();
		chk(usr_ready, 2'h2);
		cfg_chan_en = 2'h3;
		take(rows[5]);
		link_xon = 2'h1;
		offer(rows[2]);
		quiet();
		cfg_force = 1'h1;
		cfg_chan_en = 2'h1;
		quiet();
		cfg_chan_en = 2'h3;
		take(rows[2]);
		cfg_force = 1'h0;
		link_xon = 2'h3;
		link_ready = 1'h0;
		offer(rows[5]);
		repeat (6) @(negedge sys_clk);
		chk(link_valid, 1'h1);
		chk(bus.ready, 2'h0);
		link_ready = 1'h1;
		take(rows[5]);
		// Back-to-back requests: the request stays up between them
		ctl_req = 1'h1;
		for (int k = 0; k < 3; k++) begin
			@(negedge sys_clk);
			chk({ctl_valid, ctl_page}, {1'h1, 1'(k % 2)});
			chk(ctl_word, 64'(cfg_calendar[16*(k%2)+:16]) << 40);
		end
		ctl_req = 1'h0;
		@(negedge sys_clk);
		chk(ctl_valid, 1'h0);
		// Mid-run reset clears outputs and restarts the page order
		rst_n = 1'h0;
		@(negedge sys_clk);
		chk({usr_ready, link_valid, ctl_valid, ctl_page, ctl_word}, 69'h0);
		cfg_calendar = 32'h1234_9e9e;
		repeat (2) @(negedge sys_clk);
		rst_n = 1'h1;
		repeat (2) @(negedge sys_clk);
		ctl_req = 1'h1;
		@(negedge sys_clk);
		ctl_req = 1'h0;
		chk({ctl_valid, ctl_page, ctl_word}, {1'h1, 1'h0, 64'h009e_9e00_0000_0000});
		report_and_stop();
	end
endmodule // testbench
